// [include/audio_burst_buffer_params.svh]
`ifndef AUDIO_BURST_BUFFER_PARAMS_SVH
`define AUDIO_BURST_BUFFER_PARAMS_SVH

// Register map on the control port.
`define ADDR_MASK_LOW 12'hD65
`define ADDR_STAT_LOW 12'hD66
`define ADDR_MASK_HIGH 12'hD67
`define ADDR_STAT_HIGH 12'hD68
`define ADDR_WAKE_CTRL 12'hD69
`define ADDR_BURST_LEN 12'hD6A
`define ADDR_LINK_CTRL 12'hD6B
`define ADDR_SWITCH_FRAME 12'hD6C
`define ADDR_WAKE_DELAY 12'hD6D
`define ADDR_SAMPLE_COUNT 12'hD6E
`define ADDR_REVISION 12'hD6F

// Reset values and fixed fields.
`define STAT_LOW_RESET 8'h80
`define STAT_HIGH_USED 8'h87
// The revision code value is arbitrary.
`define REVISION_ID 5'h1A

// Field positions.
`define BIT_HS_OFF 7
`define BIT_BUF_FULL 6
`define BIT_BUF_EMPTY 5
`define BIT_WAKE_BLOCK 7
`define BIT_HALF_RATE 6
`define BIT_MASTER 1
`define BIT_RUN 0
`define THR_MSB 5
`define SLOT_MSB 7
`define SLOT_LSB 5
`define PRE_MSB 4
`define PRE_LSB 2

// Buffer and frame figures.
`define BUF_CAPACITY 11'h600
`define SAMPLE_SHIFT 3
`define SLOT_CAP 3'h6
`define POST_EXTRA 4'h2

// Timing: clock period and one wake-delay unit, both in ns.
`define CLK_PERIOD_NS 100
`define WAKE_UNIT_NS 26700

`endif

// [include/audio_burst_buffer_pkg.sv]
package audio_burst_buffer_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAKE = 4'h2,
    ST_DELAY = 4'h4,
    ST_XFER = 4'h8
  } burst_state_t;

  typedef struct packed {
    logic [7:0] maskLow;
    logic [7:0] maskHigh;
    logic [7:0] statLow;
    logic [7:0] statHigh;
    logic [7:0] wakeCtrl;
    logic [7:0] burstLen;
    logic [7:0] linkCtrl;
    logic [7:0] switchFrame;
    logic [7:0] wakeDelay;
    logic [7:0] rdData;
    logic [10:0] occupancy;
    logic [10:0] frameCounter;
    logic inBurst;
    logic firstBurstDone;
    burst_state_t st;
    logic [15:0] unitCnt;
    logic [7:0] unitsLeft;
    logic [11:0] remain;
    logic wakeLine;
    logic [1:0] bitClkSync;
    logic bitClkPrev;
    logic [1:0] frameSyncSync;
    logic frameSyncPrev;
  } state_t;

endpackage : audio_burst_buffer_pkg

// [rtl/audio_burst_buffer_and_irq.sv]
// Overview of operation
// - Reading a status register clears it; low status resets to 0x80.
// - Mask bit 1 lets its flag raise the interrupt; 0 blocks it.
// - Buffer full sets low bit 6; buffer empty sets low bit 5.
// - Saturation flags: bit4 DA gain, 3 AD gain, 2 AD dsp, 1 DA dsp, 0 sidetone.
// - Low bit 7 is 1 while both headset drivers are off.
// - High status: left headset short bit 2, right bit 1, earpiece bit 0.
// - High bit 7 reports negative supply ready; bits 6 to 3 reserved.
// - Block bit set stops the capture data line from waking the source.
// - Clock-select 0 asks 38.4 MHz burst bit clock, 1 asks 19.2 MHz.
// - Threshold N wakes when buffer holds fewer than 8N samples; zero disables.
// - Master burst length N requests 8N samples per wake; zero requests nothing.
// - A wake-up is a rising edge on the first capture data line.
// - Burst frames end with extra slots: codes 0-5 give 0-5, 11x gives 6.
// - Startup code N adds N clocks before first sync, N+2 after last bit; code 0 adds none after.
// - Master-select 0 makes the buffer link slave, 1 makes it master.
// - Run bit gates the block clock; burst-enable input enters burst mode.
// - Eleven-bit frame counter wraps 2047 to 0, cleared on start or normal.
// - Frame where counter equals switch value times 8 is last normal frame.
// - Wait delay times 26.7 us from wake to burst, except first burst.
// - Sample-count register reads occupancy divided by eight.
// - Revision register shows a five-bit code in bits 4 to 0.
`timescale 1ns/10ps
`include "audio_burst_buffer_params.svh"
`default_nettype none

module audio_burst_buffer_and_irq #(
  parameter int WAKE_UNIT_CYCLES = `WAKE_UNIT_NS / `CLK_PERIOD_NS
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Register port.
  input wire logic [11:0] regAddr,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // Codec event sources, same clock.
  input wire logic headsetDriversOff,
  input wire logic playGainClip,
  input wire logic captureGainClip,
  input wire logic captureDspClip,
  input wire logic playDspClip,
  input wire logic sidetoneClip,
  input wire logic negSupplyReady,
  input wire logic leftHeadsetShort,
  input wire logic rightHeadsetShort,
  input wire logic earpieceShort,
  // Digital interface control, same clock.
  input wire logic burstModeEnable,
  input wire logic interfaceStart,
  input wire logic linkSampleValid,
  input wire logic playSampleTaken,
  // Link pins, asynchronous.
  input wire logic firstLinkBitClock,
  input wire logic linkFrameSync,
  // Link outputs.
  output logic firstCaptureDataLine,
  output logic firstCaptureDataLineOe,
  output logic burstClockHalfRate,
  output logic burstBlockClockOn,
  output logic burstMasterSelect,
  output logic linkInBurst,
  output logic [2:0] extraSlotCount,
  output logic [2:0] startupPreClocks,
  output logic [3:0] startupPostClocks,
  // Interrupt.
  output logic audioIrq
);

  localparam audio_burst_buffer_pkg::state_t ResetState = '{
    statLow: `STAT_LOW_RESET,
    st: audio_burst_buffer_pkg::ST_IDLE,
    default: '0
  };

  audio_burst_buffer_pkg::state_t s_q;
  audio_burst_buffer_pkg::state_t s_d;

  logic [7:0] setLow;
  logic [7:0] setHigh;
  logic rdLow;
  logic rdHigh;
  logic frameEdge;
  logic bitClkRise;
  logic [10:0] switchPoint;
  logic [10:0] wakeLevel;
  logic masterActive;
  logic wakeWanted;
  logic bufFullEvent;
  logic bufEmptyEvent;
  logic [2:0] preCode;

  ////////////////////////////////////////////////////////////////////////////
  // Combinational helpers.

  assign rdLow = regRdEn && (regAddr == `ADDR_STAT_LOW);
  assign rdHigh = regRdEn && (regAddr == `ADDR_STAT_HIGH);
  assign bitClkRise = s_q.bitClkSync[1] && !s_q.bitClkPrev;
  // A frame starts when sync is seen high at a bit clock edge after being low.
  assign frameEdge = bitClkRise && s_q.frameSyncSync[1] && !s_q.frameSyncPrev;
  assign switchPoint = {s_q.switchFrame, 3'h0};
  assign wakeLevel = {2'h0, s_q.wakeCtrl[`THR_MSB:0], 3'h0};
  assign masterActive = s_q.linkCtrl[`BIT_RUN] && s_q.linkCtrl[`BIT_MASTER] && s_q.inBurst;
  assign wakeWanted = (s_q.wakeCtrl[`THR_MSB:0] != 6'h00) && !s_q.wakeCtrl[`BIT_WAKE_BLOCK] &&
                      (s_q.occupancy < wakeLevel);
  // Full is reached by a write at the last free place or a write into a full buffer.
  assign bufFullEvent = linkSampleValid && !playSampleTaken && (s_q.occupancy >= `BUF_CAPACITY - 11'h001);
  assign bufEmptyEvent = playSampleTaken && !linkSampleValid && (s_q.occupancy <= 11'h001);
  assign setLow = {headsetDriversOff, bufFullEvent, bufEmptyEvent, playGainClip,
                   captureGainClip, captureDspClip, playDspClip, sidetoneClip};
  assign setHigh = {negSupplyReady, 4'h0, leftHeadsetShort, rightHeadsetShort, earpieceShort};

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    s_d = s_q;

    // Pin synchronisers: the first stage feeds only the second.
    s_d.bitClkSync = {s_q.bitClkSync[0], firstLinkBitClock};
    s_d.frameSyncSync = {s_q.frameSyncSync[0], linkFrameSync};
    s_d.bitClkPrev = s_q.bitClkSync[1];
    if (bitClkRise) begin
      s_d.frameSyncPrev = s_q.frameSyncSync[1];
    end

    // Register writes.
    if (regWrEn) begin
      case (regAddr)
        `ADDR_MASK_LOW: s_d.maskLow = regWrData;
        `ADDR_MASK_HIGH: s_d.maskHigh = regWrData & `STAT_HIGH_USED;
        `ADDR_WAKE_CTRL: s_d.wakeCtrl = regWrData;
        `ADDR_BURST_LEN: s_d.burstLen = regWrData;
        `ADDR_LINK_CTRL: s_d.linkCtrl = regWrData;
        `ADDR_SWITCH_FRAME: s_d.switchFrame = regWrData;
        `ADDR_WAKE_DELAY: s_d.wakeDelay = regWrData;
        default: begin
        end
      endcase
    end

    // Register reads; unmapped addresses read zero.
    if (regRdEn) begin
      case (regAddr)
        `ADDR_MASK_LOW: s_d.rdData = s_q.maskLow;
        `ADDR_STAT_LOW: s_d.rdData = s_q.statLow;
        `ADDR_MASK_HIGH: s_d.rdData = s_q.maskHigh;
        `ADDR_STAT_HIGH: s_d.rdData = s_q.statHigh;
        `ADDR_WAKE_CTRL: s_d.rdData = s_q.wakeCtrl;
        `ADDR_BURST_LEN: s_d.rdData = s_q.burstLen;
        `ADDR_LINK_CTRL: s_d.rdData = s_q.linkCtrl;
        `ADDR_SWITCH_FRAME: s_d.rdData = s_q.switchFrame;
        `ADDR_WAKE_DELAY: s_d.rdData = s_q.wakeDelay;
        `ADDR_SAMPLE_COUNT: s_d.rdData = s_q.occupancy[10:`SAMPLE_SHIFT];
        `ADDR_REVISION: s_d.rdData = {3'h0, `REVISION_ID};
        default: s_d.rdData = 8'h00;
      endcase
    end

    // Sticky flags: a read clears, a same-cycle event still lands.
    s_d.statLow = (rdLow ? 8'h00 : s_q.statLow) | setLow;
    s_d.statHigh = (rdHigh ? 8'h00 : s_q.statHigh) | setHigh;

    // Occupancy; writes into a full buffer are dropped.
    if (linkSampleValid && !playSampleTaken && s_q.occupancy != `BUF_CAPACITY) begin
      s_d.occupancy = s_q.occupancy + 11'h001;
    end else if (playSampleTaken && !linkSampleValid && s_q.occupancy != 11'h000) begin
      s_d.occupancy = s_q.occupancy - 11'h001;
    end

    // Frame counter and the switch into burst mode.
    if (interfaceStart || !burstModeEnable) begin
      s_d.frameCounter = 11'h000;
      s_d.inBurst = 1'b0;
    end else if (frameEdge) begin
      s_d.frameCounter = s_q.frameCounter + 11'h001;
      if (!s_q.inBurst && s_q.frameCounter == switchPoint) begin
        s_d.inBurst = 1'b1;
      end
    end

    // Wake-up and burst sequencing in master mode.
    case (s_q.st)
      audio_burst_buffer_pkg::ST_IDLE: begin
        s_d.wakeLine = 1'b0;
        if (masterActive && wakeWanted) begin
          s_d.st = audio_burst_buffer_pkg::ST_WAKE;
          s_d.wakeLine = 1'b1;
        end
      end
      audio_burst_buffer_pkg::ST_WAKE: begin
        s_d.remain = {1'b0, s_q.burstLen, 3'h0};
        s_d.unitsLeft = s_q.wakeDelay;
        s_d.unitCnt = 16'h0000;
        if (!s_q.firstBurstDone || s_q.wakeDelay == 8'h00) begin
          s_d.st = audio_burst_buffer_pkg::ST_XFER;
        end else begin
          s_d.st = audio_burst_buffer_pkg::ST_DELAY;
        end
      end
      audio_burst_buffer_pkg::ST_DELAY: begin
        if (s_q.unitCnt == 16'(WAKE_UNIT_CYCLES - 1)) begin
          s_d.unitCnt = 16'h0000;
          s_d.unitsLeft = s_q.unitsLeft - 8'h01;
          if (s_q.unitsLeft == 8'h01) begin
            s_d.st = audio_burst_buffer_pkg::ST_XFER;
          end
        end else begin
          s_d.unitCnt = s_q.unitCnt + 16'h0001;
        end
      end
      audio_burst_buffer_pkg::ST_XFER: begin
        if (s_q.remain == 12'h000 || (linkSampleValid && s_q.remain == 12'h001)) begin
          s_d.remain = 12'h000;
          s_d.st = audio_burst_buffer_pkg::ST_IDLE;
          s_d.wakeLine = 1'b0;
          s_d.firstBurstDone = 1'b1;
        end else if (linkSampleValid) begin
          s_d.remain = s_q.remain - 12'h001;
        end
      end
      default: begin
        s_d.st = audio_burst_buffer_pkg::ST_IDLE;
        s_d.wakeLine = 1'b0;
      end
    endcase

    // Leaving burst mode or master operation abandons any pending burst.
    if (!masterActive) begin
      s_d.st = audio_burst_buffer_pkg::ST_IDLE;
      s_d.wakeLine = 1'b0;
    end
    if (!s_q.inBurst) begin
      s_d.firstBurstDone = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= ResetState;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign preCode = s_q.linkCtrl[`PRE_MSB:`PRE_LSB];
  assign regRdData = s_q.rdData;
  assign firstCaptureDataLine = s_q.wakeLine;
  // The line is only driven while this end masters the burst link.
  assign firstCaptureDataLineOe = masterActive;
  assign burstClockHalfRate = s_q.wakeCtrl[`BIT_HALF_RATE];
  assign burstBlockClockOn = s_q.linkCtrl[`BIT_RUN];
  assign burstMasterSelect = s_q.linkCtrl[`BIT_MASTER];
  assign linkInBurst = s_q.inBurst;
  assign extraSlotCount = (s_q.linkCtrl[`SLOT_MSB:`SLOT_LSB + 1] == 2'h3) ? `SLOT_CAP :
                          s_q.linkCtrl[`SLOT_MSB:`SLOT_LSB];
  assign startupPreClocks = preCode;
  assign startupPostClocks = (preCode == 3'h0) ? 4'h0 : {1'b0, preCode} + `POST_EXTRA;
  assign audioIrq = |(s_q.statLow & s_q.maskLow) || |(s_q.statHigh & s_q.maskHigh);

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence wakeRaised;
    !firstCaptureDataLine ##1 firstCaptureDataLine;
  endsequence

  // The last counted sample of a burst, seen while the line is still up.
  sequence lastSample;
    s_q.st == audio_burst_buffer_pkg::ST_XFER && linkSampleValid && s_q.remain == 12'h001;
  endsequence

  a_irq_mask_gate: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.maskLow == 8'h00 && s_q.maskHigh == 8'h00 |-> !audioIrq)
    else $error("interrupt raised with every mask bit clear");

  // An interrupt can only appear after a new event or a mask write, never on its own.
  a_irq_rise_cause: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(audioIrq) |-> $past(regWrEn) || $past(setLow) != 8'h00 || $past(setHigh) != 8'h00)
    else $error("interrupt rose without a cause");

  a_read_clears_low: assert property (@(posedge clk) disable iff (sys_rst)
    rdLow && setLow == 8'h00 |=> s_q.statLow == 8'h00)
    else $error("low status not cleared by read");

  a_flag_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.statHigh[0] && !rdHigh |=> s_q.statHigh[0])
    else $error("event flag lost without a read");

  a_full_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
    bufFullEvent |=> s_q.statLow[`BIT_BUF_FULL])
    else $error("buffer full event not flagged");

  a_wake_rising_edge: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.st == audio_burst_buffer_pkg::ST_IDLE && masterActive && wakeWanted |-> wakeRaised)
    else $error("wake-up not a rising edge");

  a_block_no_wake: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.wakeCtrl[`BIT_WAKE_BLOCK] |=> !$rose(firstCaptureDataLine))
    else $error("blocked line still woke the source");

  a_first_no_delay: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.st == audio_burst_buffer_pkg::ST_WAKE && !s_q.firstBurstDone && masterActive
    |=> s_q.st == audio_burst_buffer_pkg::ST_XFER)
    else $error("first burst was delayed");

  a_frame_reset: assert property (@(posedge clk) disable iff (sys_rst)
    interfaceStart |=> s_q.frameCounter == 11'h000 && !linkInBurst)
    else $error("frame counter not reset on start");

  a_switch_frame: assert property (@(posedge clk) disable iff (sys_rst)
    frameEdge && burstModeEnable && !interfaceStart && !s_q.inBurst && s_q.frameCounter == switchPoint
    |=> linkInBurst)
    else $error("burst mode missed its switch frame");

  a_count_read: assert property (@(posedge clk) disable iff (sys_rst)
    regRdEn && regAddr == `ADDR_SAMPLE_COUNT |=> regRdData == $past(s_q.occupancy[10:`SAMPLE_SHIFT]))
    else $error("sample count read wrong");

  a_empty_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
    bufEmptyEvent |=> s_q.statLow[`BIT_BUF_EMPTY])
    else $error("buffer empty event not flagged");

  // The headset-off level keeps re-setting its flag while it stands.
  a_hs_off_flag: assert property (@(posedge clk) disable iff (sys_rst)
    headsetDriversOff |=> s_q.statLow[`BIT_HS_OFF])
    else $error("headset off state not flagged");

  a_read_clears_high: assert property (@(posedge clk) disable iff (sys_rst)
    rdHigh && setHigh == 8'h00 |=> s_q.statHigh == 8'h00)
    else $error("high status not cleared by read");

  a_high_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
    (s_q.statHigh & ~`STAT_HIGH_USED) == 8'h00 && (s_q.maskHigh & ~`STAT_HIGH_USED) == 8'h00)
    else $error("reserved high bits not zero");

  a_zero_thr_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.st == audio_burst_buffer_pkg::ST_IDLE && s_q.wakeCtrl[`THR_MSB:0] == 6'h00 |=> !firstCaptureDataLine)
    else $error("wake-up with zero threshold");

  a_burst_end_drop: assert property (@(posedge clk) disable iff (sys_rst)
    lastSample |=> !firstCaptureDataLine)
    else $error("wake line stayed up after the last sample");

  // The burst may not start while a delay unit is still being counted.
  a_delay_held: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.st == audio_burst_buffer_pkg::ST_DELAY && masterActive && s_q.unitCnt != 16'(WAKE_UNIT_CYCLES - 1)
    |=> s_q.st == audio_burst_buffer_pkg::ST_DELAY)
    else $error("burst started inside the wake delay");

  // A slave or stopped block must leave the wake line to the far side.
  a_line_drive_gate: assert property (@(posedge clk) disable iff (sys_rst)
    !burstMasterSelect || !burstBlockClockOn |-> !firstCaptureDataLineOe)
    else $error("wake line driven while slave or stopped");

  // Writes into a full buffer are dropped, so the count never passes capacity.
  a_occupancy_cap: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.occupancy <= `BUF_CAPACITY)
    else $error("buffer occupancy above capacity");

endmodule : audio_burst_buffer_and_irq

`default_nettype wire

// [tb/burst_link_partner.sv]
`timescale 1ns/10ps
`default_nettype none

module burst_link_partner (
  // Clock.
  input wire logic clk,
  // Control from the bench.
  input wire logic frameEn,
  input wire logic cntClr,
  // Wake line from the device.
  input wire logic wake,
  input wire logic wakeOe,
  // Link towards the device.
  output logic bitClk,
  output logic fSync,
  output logic sampleValid,
  output logic [7:0] sent
);
  logic [1:0] ph = 2'h0;
  logic valid_q = 1'b0;
  logic [7:0] sent_q = 8'h00;
  int b;

  ////////////////////////////////////////////////////////////////////////////
  // The bit clock stands still low between frames; it is not free running.
  initial begin
    bitClk = 1'b0;
    fSync = 1'b0;
    #137;
    forever begin
      if (!frameEn) @(posedge frameEn);
      for (b = 0; b < 4; b++) begin
        fSync = (b == 0);
        #400 bitClk = 1'b1;
        #400 bitClk = 1'b0;
      end
      #1600;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Samples flow whenever the line is high, delay or not, so that samples
  // sent too early show up as a longer burst. The first one follows the
  // rising edge by four clocks, so the stream phase is the same every burst.
  always @(negedge clk) begin
    ph <= (wake && wakeOe) ? ph + 2'h1 : 2'h0;
    if (cntClr) sent_q <= 8'h00;
    else if (valid_q) sent_q <= sent_q + 8'h01;
    valid_q <= wake && wakeOe && (ph == 2'h3);
  end

  assign sampleValid = valid_q;
  assign sent = sent_q;
endmodule : burst_link_partner

`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "audio_burst_buffer_params.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t got %0h expected %0h", $time, g, e); end end
`define WAITFOR(c, m) for (n = 0; n < m && !(c); n++) @(negedge clk);

module tb_top;
  logic clk = 0, sys_rst = 1, regWrEn = 0, regRdEn = 0, hsOff = 0, modeEn = 0, ifStart = 0;
  logic tbValid = 0, taken = 0, frameEn = 0, cntClr = 0;
  logic [11:0] regAddr = 12'h000;
  logic [7:0] regWrData = 8'h00, rdv, v, bm, hi;
  logic [8:0] ev = 9'h000;
  wire logic [7:0] regRdData, pSent;
  wire logic bitClk, fSync, pValid, wake, wakeOe, halfRate, runOn, master, inBurst, irq;
  wire logic [2:0] slots, pre;
  wire logic [3:0] post;
  int num_errors = 0, cmp_count = 0, i, n, d1, d2;
  logic [11:0] rwList [7] = '{12'hD65, 12'hD67, 12'hD69, 12'hD6A, 12'hD6B, 12'hD6C, 12'hD6D};

  initial forever #50 clk = ~clk;

  localparam int UnitCycles = 4;

  audio_burst_buffer_and_irq #(.WAKE_UNIT_CYCLES(UnitCycles)) u_audio_burst_buffer_and_irq (
    .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regWrData(regWrData), .regRdData(regRdData), .headsetDriversOff(hsOff), .playGainClip(ev[4]),
    .captureGainClip(ev[3]), .captureDspClip(ev[2]), .playDspClip(ev[1]), .sidetoneClip(ev[0]),
    .negSupplyReady(ev[8]), .leftHeadsetShort(ev[7]), .rightHeadsetShort(ev[6]), .earpieceShort(ev[5]),
    .burstModeEnable(modeEn), .interfaceStart(ifStart), .linkSampleValid(tbValid | pValid),
    .playSampleTaken(taken), .firstLinkBitClock(bitClk), .linkFrameSync(fSync),
    .firstCaptureDataLine(wake), .firstCaptureDataLineOe(wakeOe), .burstClockHalfRate(halfRate),
    .burstBlockClockOn(runOn), .burstMasterSelect(master), .linkInBurst(inBurst),
    .extraSlotCount(slots), .startupPreClocks(pre), .startupPostClocks(post), .audioIrq(irq));

  burst_link_partner u_burst_link_partner (.clk(clk), .frameEn(frameEn), .cntClr(cntClr), .wake(wake),
    .wakeOe(wakeOe), .bitClk(bitClk), .fSync(fSync), .sampleValid(pValid), .sent(pSent));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [2:0] slotsFor(input logic [2:0] c);
    return (c[2] && c[1]) ? 3'h6 : c;
  endfunction : slotsFor

  function automatic logic [3:0] postFor(input logic [2:0] c);
    return (c == 3'h0) ? 4'h0 : {1'b0, c} + 4'h2;
  endfunction : postFor

  function automatic logic [7:0] evBit(input int k);
    return 8'h01 << ((k < 5) ? k : (k < 8) ? k - 5 : 7);
  endfunction : evBit

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
  endtask : wr

  task automatic chkRd(input logic [11:0] a, input logic [7:0] e);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    rdv = regRdData;
    `CHK(rdv, e)
  endtask : chkRd

  task automatic pulses(input int k, input bit w);
    repeat (k) begin
      @(negedge clk);
      tbValid = w;
      taken = !w;
      @(negedge clk);
      tbValid = 1'b0;
      taken = 1'b0;
    end
  endtask : pulses

  task automatic burst(output int dur);
    `WAITFOR(wake === 1'b1, 300)
    `CHK(wake, 1'b1)
    for (dur = 0; dur < 400 && wake !== 1'b0; dur++) @(negedge clk);
    // One more edge lets the partner's sample count settle.
    @(negedge clk);
    `CHK(wake, 1'b0)
  endtask : burst

  task automatic wrap_up;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(100 * 30000);
    num_errors++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'h31A2));
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    chkRd(`ADDR_STAT_LOW, `STAT_LOW_RESET);
    for (i = 12'hD64; i <= 12'hD6E; i++) chkRd(i[11:0], 8'h00);
    chkRd(12'hD70, 8'h00);
    chkRd(`ADDR_REVISION, {3'h0, `REVISION_ID});
    `CHK(rdv[7:5], 3'h0)
    foreach (rwList[k]) begin
      v = $urandom;
      wr(rwList[k], v);
      chkRd(rwList[k], (rwList[k] == `ADDR_MASK_HIGH) ? (v & `STAT_HIGH_USED) : v);
      wr(rwList[k], 8'h00);
    end
    wr(`ADDR_SAMPLE_COUNT, $urandom);
    chkRd(`ADDR_SAMPLE_COUNT, 8'h00);
    for (i = 0; i < 8; i++) begin
      wr(`ADDR_LINK_CTRL, {i[2:0], i[2:0], i[1:0]});
      `CHK({slots, pre, post}, {slotsFor(i[2:0]), i[2:0], postFor(i[2:0])})
      `CHK({master, runOn}, i[1:0])
    end
    wr(`ADDR_WAKE_CTRL, 8'h40);
    `CHK(halfRate, 1'b1)
    wr(`ADDR_WAKE_CTRL, 8'h00);
    `CHK(halfRate, 1'b0)
    wr(`ADDR_LINK_CTRL, 8'h00);
    for (i = 0; i < 9; i++) begin
      bm = evBit(i);
      v = (i < 5) ? `ADDR_STAT_LOW : `ADDR_STAT_HIGH;
      @(negedge clk) ev[i] = 1'b1;
      @(negedge clk) ev[i] = 1'b0;
      repeat (3) @(negedge clk);
      `CHK(irq, 1'b0)
      wr({4'hD, v} - 12'h1, bm);
      `CHK(irq, 1'b1)
      chkRd({4'hD, v}, bm);
      `CHK(irq, 1'b0)
      wr({4'hD, v} - 12'h1, 8'h00);
    end
    hsOff = 1'b1;
    chkRd(`ADDR_STAT_LOW, 8'h80);
    chkRd(`ADDR_STAT_LOW, 8'h80);
    hsOff = 1'b0;
    chkRd(`ADDR_STAT_LOW, 8'h80);
    chkRd(`ADDR_STAT_LOW, 8'h00);
    pulses(1536, 1'b1);
    pulses(1, 1'b1);
    chkRd(`ADDR_SAMPLE_COUNT, 8'hC0);
    chkRd(`ADDR_STAT_LOW, 8'h40);
    pulses(1536, 1'b0);
    chkRd(`ADDR_STAT_LOW, 8'h20);
    chkRd(`ADDR_SAMPLE_COUNT, 8'h00);
    // Burst length of 8 samples keeps well inside the buffer.
    wr(`ADDR_BURST_LEN, 8'h01);
    // The delay stands from the start; the first burst must not wait for it.
    wr(`ADDR_WAKE_DELAY, 8'h02);
    wr(`ADDR_WAKE_CTRL, 8'h01);
    wr(`ADDR_LINK_CTRL, 8'h03);
    @(negedge clk);
    ifStart = 1'b1;
    modeEn = 1'b1;
    frameEn = 1'b1;
    @(negedge clk) ifStart = 1'b0;
    `WAITFOR(inBurst === 1'b1, 2000)
    `CHK(inBurst, 1'b1)
    `CHK(wakeOe, 1'b1)
    burst(d1);
    `CHK(pSent, 8'h08)
    chkRd(`ADDR_SAMPLE_COUNT, 8'h01);
    wr(`ADDR_WAKE_CTRL, 8'h82);
    hi = 8'h00;
    for (n = 0; n < 40; n++) @(negedge clk) hi = hi | wake;
    `CHK(hi, 8'h00)
    @(negedge clk) cntClr = 1'b1;
    @(negedge clk) cntClr = 1'b0;
    wr(`ADDR_WAKE_CTRL, 8'h02);
    burst(d2);
    `CHK(pSent > 8'h08, 1'b1)
    `CHK(d2 - d1, 2 * UnitCycles)
    chkRd(`ADDR_SAMPLE_COUNT, 8'h02);
    modeEn = 1'b0;
    repeat (3) @(negedge clk);
    `CHK({inBurst, wakeOe}, 2'b00)
    wrap_up();
  end
endmodule : tb_top

`default_nettype wire
